// ### logic/blec_boot_loader_entry_control.sv
// boot loader entry decision, password gate and serial pin front end
`timescale 1ns/10ps
module blec_boot_loader_entry_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins
  input wire logic loader_request_pin,
  input wire logic external_reset_pin_low,
  input wire logic loader_uart_receive,
  input wire logic loader_i2c_clock,
  input wire logic loader_i2c_data_in,
  // configuration and memory state
  input wire logic config_valid,
  input wire blec_pkg::blec_config_t config_word,
  input wire logic [31:0] reset_vector_word,
  input wire logic [31:0] stack_pointer_word,
  // system reset with loader entry command (same clock domain)
  input wire logic system_level_reset,
  input wire logic sysreset_loader_cmd,
  // loader core side
  input wire logic use_i2c,
  input wire logic loader_tx_bit,
  input wire logic loader_sda_drive_low,
  input wire logic pw_check,
  input wire logic [255:0] pw_candidate,
  // outputs
  output blec_pkg::blec_status_t status,
  output logic boot_level_reset,
  output logic loader_uart_transmit,
  output logic loader_i2c_data_out,
  output logic loader_i2c_data_oe
);
  import blec_pkg::*;

  blec_regs_t r;
  blec_regs_t next_r;
  blec_config_t cfg;
  logic blank_device;
  logic request_seen;

  // =====================================================================
  // configuration defaults until the store delivers a word
  always_comb begin
    if (config_valid) begin
      cfg = config_word;
    end else begin
      cfg.loader_disable = BLEC_RST_DISABLE;
      cfg.fast_boot = BLEC_RST_FAST_BOOT;
      cfg.invoke_level = BLEC_RST_INVOKE_LEVEL;
      cfg.password = '0;
    end
  end

  assign blank_device = (reset_vector_word == BLEC_ERASED_WORD) &&
                        (stack_pointer_word == BLEC_ERASED_WORD);
  assign request_seen = (r.req_sync[1] == cfg.invoke_level);

  // =====================================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.req_sync = {r.req_sync[0], loader_request_pin};
    next_r.rst_sync = {r.rst_sync[0], external_reset_pin_low};
    next_r.boot_reset_req = 1'b0;
    next_r.status.password_fail = 1'b0;
    // a low reset pin requests a reboot, which re-checks the request
    if (!r.rst_sync[1]) begin
      next_r.boot_reset_req = 1'b1;
      next_r.state = BLEC_RESET;
      next_r.status = '0;
    end else if (system_level_reset) begin
      // runtime entry remembered across the system-level reboot
      next_r.runtime_entry = sysreset_loader_cmd;
      next_r.state = BLEC_RESET;
      next_r.status = '0;
    end else begin
      case (r.state)
        BLEC_RESET: begin
          // wait for configuration; sync chain fills meanwhile
          if (config_valid) begin
            next_r.state = BLEC_SAMPLE;
          end
        end
        BLEC_SAMPLE: begin
          next_r.state = BLEC_DECIDE;
        end
        BLEC_DECIDE: begin
          next_r.status.decided = 1'b1;
          next_r.runtime_entry = 1'b0;
          if (!cfg.loader_disable && ((!cfg.fast_boot && request_seen)
              || blank_device || r.runtime_entry)) begin
            next_r.state = BLEC_LOADER;
            next_r.status.run_loader = 1'b1;
          end else begin
            next_r.state = BLEC_APP;
            next_r.status.run_application = 1'b1;
          end
        end
        BLEC_LOADER: begin
          // grant stays until the next reboot
          if (pw_check) begin
            if (pw_candidate == cfg.password) begin
              next_r.status.access_granted = 1'b1;
            end else begin
              next_r.status.password_fail = 1'b1;
            end
          end
        end
        BLEC_APP: begin
          next_r.state = BLEC_APP;
        end
        default: begin
          next_r.state = BLEC_RESET;
        end
      endcase
    end
    // serial pins only live while the loader runs; idle high otherwise
    next_r.uart_tx = 1'b1;
    next_r.i2c_data_oe = 1'b0;
    if (r.state == BLEC_LOADER) begin
      if (use_i2c) begin
        next_r.i2c_data_oe = loader_sda_drive_low;
      end else begin
        next_r.uart_tx = loader_tx_bit;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r <= '{state: BLEC_RESET, req_sync: 2'h0, rst_sync: 2'h3,
             runtime_entry: 1'b0, status: '0, uart_tx: 1'b1,
             i2c_data_oe: 1'b0, boot_reset_req: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign status = r.status;
  assign boot_level_reset = r.boot_reset_req;
  assign loader_uart_transmit = r.uart_tx;
  assign loader_i2c_data_out = 1'b0;
  assign loader_i2c_data_oe = r.i2c_data_oe;

endmodule : blec_boot_loader_entry_control

// ### logic/blec_pkg.sv
// package: constants and types for the boot loader entry control block
package blec_pkg;

  // configuration word as delivered by the non-volatile store at boot
  typedef struct packed {
    logic loader_disable;
    logic fast_boot;
    logic invoke_level;
    logic [255:0] password;
  } blec_config_t;

  // boot decision and password gate outputs
  typedef struct packed {
    logic run_loader;
    logic run_application;
    logic decided;
    logic access_granted;
    logic password_fail;
  } blec_status_t;

  typedef enum logic [2:0] {
    BLEC_RESET,
    BLEC_SAMPLE,
    BLEC_DECIDE,
    BLEC_LOADER,
    BLEC_APP
  } blec_state_t;

  localparam int BLEC_PW_BITS = 256;
  localparam logic BLEC_RST_DISABLE = 1'b0;
  localparam logic BLEC_RST_FAST_BOOT = 1'b0;
  localparam logic BLEC_RST_INVOKE_LEVEL = 1'b1;
  // erased flash reads as all ones
  localparam logic [31:0] BLEC_ERASED_WORD = 32'hFFFFFFFF;

  typedef struct packed {
    blec_state_t state;
    logic [1:0] req_sync;
    logic [1:0] rst_sync;
    logic runtime_entry;
    blec_status_t status;
    logic uart_tx;
    logic i2c_data_oe;
    logic boot_reset_req;
  } blec_regs_t;

endpackage : blec_pkg

// ### sim/blec_host.sv
// partner: external host holding the request pin and pulsing reset
`timescale 1ns/10ps
module blec_host (
  input wire logic ref_clk,
  output logic loader_request_pin,
  output logic external_reset_pin_low
);
  initial begin
    loader_request_pin = 1'b0;
    external_reset_pin_low = 1'b1;
  end
  // request stays held after the pulse so the reboot samples it
  task automatic pulse(input logic lvl);
    loader_request_pin = lvl;
    repeat (4) @(negedge ref_clk) external_reset_pin_low = 1'b0;
    @(negedge ref_clk) external_reset_pin_low = 1'b1;
  endtask : pulse
endmodule : blec_host

// ### sim/blec_properties.sv
// checker: port properties of the boot loader entry control
`timescale 1ns/10ps
module blec_properties import blec_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic external_reset_pin_low,
  input wire logic config_valid,
  input wire blec_pkg::blec_config_t config_word,
  input wire logic pw_check,
  input wire blec_pkg::blec_status_t status,
  input wire logic boot_level_reset,
  input wire logic loader_uart_transmit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // reboot starts when the reset pin returns high with a valid word at hand
  sequence s_boot; $rose(external_reset_pin_low) && config_valid; endsequence
  sequence s_pin_low; $fell(external_reset_pin_low); endsequence
  a_boot_decides: assert property (s_boot |-> ##[2:5] status.decided)
    else $error("no boot decision");
  a_pin_reboot: assert property (s_pin_low |-> ##[2:4] boot_level_reset)
    else $error("reset pin gave no boot reset");
  a_reboot_clears: assert property (boot_level_reset |=> !status.decided)
    else $error("decision kept over boot reset");
  a_disable_blocks: assert property (config_valid && config_word.loader_disable
    |-> !status.run_loader)
    else $error("loader ran while disabled");
  a_one_target: assert property (status.decided
    |-> status.run_loader ^ status.run_application)
    else $error("boot target not unique");
  a_fail_cause: assert property (status.password_fail |-> $past(pw_check))
    else $error("password fail without check");
  a_grant_loader: assert property (status.access_granted |-> status.run_loader)
    else $error("access outside loader");
  a_uart_idle: assert property (!status.decided && !$past(status.decided)
    |-> loader_uart_transmit)
    else $error("uart line not idle");
endmodule : blec_properties
bind blec_boot_loader_entry_control blec_properties u_props (.*);

// ### sim/tb_top.sv
// testbench: boot entry scenarios through the host model
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import blec_pkg::*;
  logic ref_clk = 0, reset = 1, config_valid = 0, system_level_reset = 0;
  logic sysreset_loader_cmd = 0, use_i2c = 1, loader_tx_bit = 1;
  logic loader_sda_drive_low = 0, pw_check = 0, loader_uart_receive = 0;
  logic loader_i2c_clock = 0, loader_i2c_data_in = 0;
  logic [255:0] pw_candidate = '0;
  logic [31:0] reset_vector_word = 32'h0, stack_pointer_word = 32'h0;
  blec_config_t config_word = {3'h1, {8{32'h5A3C96E1}}};
  blec_status_t status;
  logic loader_request_pin, external_reset_pin_low, boot_level_reset;
  logic loader_uart_transmit, loader_i2c_data_out, loader_i2c_data_oe;
  int fails = 0, total_checks = 0;
  always #50 ref_clk = ~ref_clk;
  blec_host host (.ref_clk(ref_clk), .loader_request_pin(loader_request_pin),
    .external_reset_pin_low(external_reset_pin_low));
  blec_boot_loader_entry_control dut (.*);
  task automatic boot(input logic lvl, input logic ldr);
    host.pulse(lvl);
    repeat (20) @(negedge ref_clk) if (status.decided === 1'b1) break;
    `CHK("run_loader", ldr, status.run_loader)
    `CHK("run_application", ~ldr, status.run_application)
  endtask : boot
  task automatic t_invoke;
    // the store delivers the as-shipped word: enabled, no fast boot, level 1
    config_valid = 1'b1;
    boot(1'b1, 1'b1);
    boot(1'b0, 1'b0);
    boot(1'b1, 1'b1);
    config_word.invoke_level = 1'b0;
    boot(1'b0, 1'b1);
    config_word.invoke_level = 1'b1;
  endtask : t_invoke
  task automatic t_fast;
    config_word.fast_boot = 1'b1;
    boot(1'b1, 1'b0);
    config_word.loader_disable = 1'b1;
    {reset_vector_word, stack_pointer_word} = {2{BLEC_ERASED_WORD}};
    boot(1'b1, 1'b0);
    config_word.loader_disable = 1'b0;
    boot(1'b0, 1'b1);
    config_word.fast_boot = 1'b0;
    {reset_vector_word, stack_pointer_word} = 64'h0;
  endtask : t_fast
  task automatic t_runtime;
    boot(1'b0, 1'b0);
    {system_level_reset, sysreset_loader_cmd} = 2'h3;
    @(negedge ref_clk) {system_level_reset, sysreset_loader_cmd} = 2'h0;
    repeat (20) @(negedge ref_clk) if (status.run_loader === 1'b1) break;
    `CHK("runtime", 1'b1, status.run_loader)
  endtask : t_runtime
  task automatic t_password;
    pw_candidate = ~config_word.password;
    pw_check = 1'b1;
    loader_sda_drive_low = 1'b1;
    loader_tx_bit = 1'b0;
    @(negedge ref_clk) pw_candidate = config_word.password;
    `CHK("password_fail", 1'b1, status.password_fail)
    `CHK("access_granted", 1'b0, status.access_granted)
    `CHK("i2c_data_oe", 1'b1, loader_i2c_data_oe)
    `CHK("uart_transmit", 1'b1, loader_uart_transmit)
    `CHK("i2c_data_out", 1'b0, loader_i2c_data_out)
    @(negedge ref_clk) pw_check = 1'b0;
    `CHK("access_granted", 1'b1, status.access_granted)
    use_i2c = 1'b0;
    @(negedge ref_clk);
    `CHK("uart_transmit", 1'b0, loader_uart_transmit)
    `CHK("i2c_data_oe", 1'b0, loader_i2c_data_oe)
  endtask : t_password
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    t_invoke;
    t_fast;
    t_runtime;
    t_password;
    end_of_test;
  end
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
endmodule : tb_top
